// file: hw/ppcb_pkg.sv
package ppcb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int HOST_W  = 8;
  localparam int STAT_W  = 3;
  localparam int PDATA_W = 8;
  localparam int PADDR_W = 20;
  localparam int NYB_W   = 4;
  localparam int PROF_W  = 4;
  localparam int COUNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Host port and peripheral address bit positions
  localparam int BIT_STROBE = 0;
  localparam int BIT_XCLK   = 1;
  localparam int NYB_LO     = 2;
  localparam int NYB_HI     = 5;
  localparam int BIT_CSEL   = 5;
  localparam int BIT_XRST   = 6;
  localparam int BIT_PROG   = 7;
  localparam int STAT_LO    = 3;
  localparam int STAT_HI    = 5;
  localparam int ADDR_HLTH  = 19;
  localparam int PROF_AB_HI = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Profile codes
  localparam logic [3:0] PROF_I2C   = 4'h0;
  localparam logic [3:0] PROF_CODEC = 4'h1;
  localparam logic [3:0] PROF_XCHG  = 4'h2;
  localparam logic [3:0] PROF_VEC   = 4'h3;
  localparam logic [1:0] PROF_RSVD  = 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Drive masks per profile
  localparam logic [7:0] PD_EN_NONE  = 8'h00;
  localparam logic [7:0] PD_EN_CFG   = 8'hFF;
  localparam logic [7:0] PD_EN_I2C   = 8'h03;
  localparam logic [7:0] PD_EN_CODEC = 8'h0B;
  localparam logic [7:0] PD_EN_XCHG  = 8'h3C;
  localparam logic [7:0] PD_EN_VEC   = 8'h7F;
  localparam logic [2:0] ST_EN_NONE  = 3'h0;
  localparam logic [2:0] ST_EN_I2C   = 3'h3;
  localparam logic [2:0] ST_EN_CODEC = 3'h2;
  localparam logic [2:0] ST_EN_ALL   = 3'h7;
  localparam logic [2:0] ST_EN_HLTH  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Fixed levels and reset values
  localparam logic MODE_SLAVE_PAR = 1'b0;
  localparam logic TCK_IDLE       = 1'b0;
  localparam logic PROG_RST       = 1'b1;
  localparam logic CCLK_RST       = 1'b1;
  localparam logic STROBE_RST     = 1'b1;
  localparam logic [31:0] USER_SIGNATURE = 32'h5A3C0E71;  // Arbitrary value

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int CCLK_SETUP_NS   = 16;
  localparam int CCLK_SETUP_CYC  = (CCLK_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic {ST_UNCFG, ST_CFG} ppcb_state_t;
  typedef enum logic [2:0] {PR_I2C, PR_CODEC, PR_XCHG, PR_VEC, PR_RSVD, PR_HLTH} ppcb_prof_t;

endpackage : ppcb_pkg

// file: hw/ppcb_nyb_if.sv
`timescale 1ns/10ps
interface ppcb_nyb_if;
  logic [ppcb_pkg::NYB_W-1:0] held_nybble;
  logic                       captured;

  modport producer (output held_nybble, output captured);
  modport consumer (input held_nybble, input captured);
endinterface : ppcb_nyb_if

// file: hw/ppcb_sync.sv
`timescale 1ns/10ps
module ppcb_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta[i] <= RST_VAL[i];
        q[i]    <= RST_VAL[i];
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule : ppcb_sync

// file: hw/ppcb_nyb_capture.sv
`timescale 1ns/10ps
module ppcb_nyb_capture (
  // Clocks and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       cfg_link_clk,
  // Raw nybble pins
  input  wire logic [ppcb_pkg::NYB_W-1:0] nybble_pins,
  // To the core
  ppcb_nyb_if.producer                    nyb
);

  logic [ppcb_pkg::NYB_W-1:0] link_nybble;
  logic                       link_tog;
  logic [2:0]                 tog_sync;
  wire                        tog_edge = tog_sync[2] ^ tog_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Falling edge of the strobe pin is the rising edge of its inverse
  always_ff @(negedge cfg_link_clk or posedge rst) begin
    if (rst) begin
      link_nybble <= 4'h0;
      link_tog    <= 1'b0;
    end else begin
      link_nybble <= nybble_pins;  // RULE6
      link_tog    <= ~link_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggle crossing; word is stable at least two clock cycles before it is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_sync        <= 3'h0;
      nyb.held_nybble <= 4'h0;
      nyb.captured    <= 1'b0;
    end else begin
      tog_sync     <= {tog_sync[1:0], link_tog};
      nyb.captured <= tog_edge;
      if (tog_edge) begin
        nyb.held_nybble <= link_nybble;  // RULE6
      end
    end
  end

endmodule : ppcb_nyb_capture

// file: hw/ppcb_top.sv
// Contract
// RULE1 - Mode select pin to the FPGA is held low for slave parallel loading.
// RULE2 - FPGA program-initiate follows host data bit 7; host starts loading by lowering it.
// RULE3 - While done is low, chip-select and write-strobe are driven low.
// RULE4 - Once done is high, chip-select and write-strobe are no longer forced low.
// RULE5 - Host sends each byte as two nybbles on data bits 2..5, upper first.
// RULE6 - Upper nybble is held on the falling edge of host data bit 0.
// RULE7 - Unconfigured: peripheral data is held upper nybble above live host nybble.
// RULE8 - FPGA configuration clock is the inverse of the internal configuration clock.
// RULE9 - Boundary-scan clock to the FPGA stays low always.
// RULE10 - Configured: chip-select and write-strobe carry host interchange clock and reset.
// RULE11 - Configured: chip-select is inverse of host bit 1, write-strobe is host bit 6.
// RULE12 - Profile address is init line above peripheral address bits 2..0.
// RULE13 - Profile 0000 opens the two-wire clock and data path.
// RULE14 - Two-wire: data 0 = not host 1, data 1 = host 6, status 3..4 = addr 3..4.
// RULE15 - Profile 0001 opens the codec programming path.
// RULE16 - Codec: data 0 = not host 1, 1 = host 6, 3 = host 5; status 4 = data 2.
// RULE17 - Profile 0010 opens the bidirectional data interchange path.
// RULE18 - Interchange: data 5..2 = host 5..2, status 5..3 = address 5..3.
// RULE19 - Profile 0011 passes host data to low seven data bits, returns address 5..3.
// RULE20 - Profiles 01XX open no path at all.
// RULE21 - Init high: address bit 19 goes to status 5, all else isolated.
// RULE22 - A fixed four-character user signature is carried by the design.
// RULE23 - Peripheral data, address and status are undriven unless a path drives them.
`timescale 1ns/10ps
module ppcb_top (
  // Clocks and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         cfg_link_clk,
  // Host parallel port
  input  wire logic [ppcb_pkg::HOST_W-1:0]  host_port_data,
  output logic      [ppcb_pkg::STAT_W-1:0]  host_port_status,
  output logic      [ppcb_pkg::STAT_W-1:0]  host_port_status_oe,
  // FPGA configuration pins
  output logic                              cfg_mode_sel_pin,
  output logic                              fpga_prog_n,
  output logic                              fpga_cclk,
  output logic                              fpga_csel_n,
  output logic                              fpga_csel_n_oe,
  output logic                              fpga_wstrb_n,
  output logic                              fpga_wstrb_n_oe,
  input  wire logic                         fpga_init_n,
  input  wire logic                         fpga_done,
  output logic                              fpga_tck,
  // Peripheral bus
  input  wire logic [ppcb_pkg::PDATA_W-1:0] periph_data_bus_in,
  output logic      [ppcb_pkg::PDATA_W-1:0] periph_data_bus_out,
  output logic      [ppcb_pkg::PDATA_W-1:0] periph_data_bus_oe,
  input  wire logic [ppcb_pkg::PADDR_W-1:0] periph_addr_bus_in,
  output logic      [ppcb_pkg::PADDR_W-1:0] periph_addr_bus_out,
  output logic      [ppcb_pkg::PADDR_W-1:0] periph_addr_bus_oe,
  // Status
  output logic      [31:0]                  user_signature,
  output logic                              cfg_active,
  output logic      [ppcb_pkg::PROF_W-1:0]  profile_sel,
  output logic      [ppcb_pkg::COUNT_W-1:0] cfg_byte_count
);

  localparam int SYNC_W = ppcb_pkg::HOST_W + ppcb_pkg::PDATA_W + ppcb_pkg::PADDR_W + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [SYNC_W-1:0]                  sync_q;
  logic [ppcb_pkg::HOST_W-1:0]        s_host;
  logic [ppcb_pkg::PDATA_W-1:0]       s_pd;
  logic [ppcb_pkg::PADDR_W-1:0]       s_pa;
  logic                               s_done;
  logic                               s_init_n;

  ppcb_pkg::ppcb_state_t              state;
  ppcb_pkg::ppcb_state_t              next_state;
  ppcb_pkg::ppcb_prof_t               prof;

  logic [ppcb_pkg::CCLK_SETUP_CYC-1:0] strobe_dly;
  logic                               strobe_prev;
  logic                               cclk_rise;

  logic [ppcb_pkg::PROF_W-1:0]        profile_addr;
  logic                               sel_i2c;
  logic                               sel_codec;
  logic                               sel_xchg;
  logic                               sel_vec;
  logic                               sel_rsvd;
  logic                               sel_hlth;

  logic [ppcb_pkg::PDATA_W-1:0]       cfg_pd_val;
  logic [ppcb_pkg::PDATA_W-1:0]       i2c_pd_val;
  logic [ppcb_pkg::PDATA_W-1:0]       codec_pd_val;
  logic [ppcb_pkg::PDATA_W-1:0]       xchg_pd_val;
  logic [ppcb_pkg::PDATA_W-1:0]       vec_pd_val;
  logic [ppcb_pkg::STAT_W-1:0]        i2c_st_val;
  logic [ppcb_pkg::STAT_W-1:0]        codec_st_val;
  logic [ppcb_pkg::STAT_W-1:0]        xchg_st_val;
  logic [ppcb_pkg::STAT_W-1:0]        hlth_st_val;

  logic [ppcb_pkg::PDATA_W-1:0]       prof_pd_val;
  logic [ppcb_pkg::PDATA_W-1:0]       prof_pd_en;
  logic [ppcb_pkg::STAT_W-1:0]        prof_st_val;
  logic [ppcb_pkg::STAT_W-1:0]        prof_st_en;

  logic [ppcb_pkg::PDATA_W-1:0]       next_pd_out;
  logic [ppcb_pkg::PDATA_W-1:0]       next_pd_oe;
  logic [ppcb_pkg::STAT_W-1:0]        next_st_out;
  logic [ppcb_pkg::STAT_W-1:0]        next_st_oe;
  logic                               next_csel_n;
  logic                               next_wstrb_n;
  logic [ppcb_pkg::COUNT_W-1:0]       next_byte_count;

  ppcb_nyb_if                         nyb ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and nybble capture

  // Host lines restart at idle, so no false program pulse or clock edge follows reset
  ppcb_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_W'({ppcb_pkg::PROG_RST, 6'h00, ppcb_pkg::STROBE_RST}))
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({fpga_init_n, fpga_done, periph_addr_bus_in, periph_data_bus_in, host_port_data}),
    .q   (sync_q)
  );

  assign s_host   = sync_q[ppcb_pkg::HOST_W-1:0];
  assign s_pd     = sync_q[ppcb_pkg::HOST_W +: ppcb_pkg::PDATA_W];
  assign s_pa     = sync_q[ppcb_pkg::HOST_W + ppcb_pkg::PDATA_W +: ppcb_pkg::PADDR_W];
  assign s_done   = sync_q[SYNC_W-2];
  assign s_init_n = sync_q[SYNC_W-1];

  // Host is expected to present upper then lower nybble per byte
  ppcb_nyb_capture u_capture (  // RULE5
    .clk          (clk),
    .rst          (rst),
    .cfg_link_clk (cfg_link_clk),
    .nybble_pins  (host_port_data[ppcb_pkg::NYB_HI:ppcb_pkg::NYB_LO]),
    .nyb          (nyb.producer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and profile decode

  assign next_state   = s_done ? ppcb_pkg::ST_CFG : ppcb_pkg::ST_UNCFG;
  assign profile_addr = {s_init_n, s_pa[ppcb_pkg::PROF_AB_HI:0]};  // RULE12

  assign sel_hlth  = profile_addr[3];  // RULE21
  assign sel_rsvd  = (profile_addr[3:2] == ppcb_pkg::PROF_RSVD);  // RULE20
  assign sel_i2c   = (profile_addr == ppcb_pkg::PROF_I2C);  // RULE13
  assign sel_codec = (profile_addr == ppcb_pkg::PROF_CODEC);  // RULE15
  assign sel_xchg  = (profile_addr == ppcb_pkg::PROF_XCHG);  // RULE17
  assign sel_vec   = (profile_addr == ppcb_pkg::PROF_VEC);  // RULE19

  ////////////////////////////////////////////////////////////////////////////
  // Configuration byte and clock

  // Upper half is the held nybble, lower half still live on the pins
  assign cfg_pd_val = {nyb.held_nybble, s_host[ppcb_pkg::NYB_HI:ppcb_pkg::NYB_LO]};  // RULE7

  // Delay keeps data on the bus ahead of the rising configuration clock
  assign cclk_rise = strobe_dly[ppcb_pkg::CCLK_SETUP_CYC-1] & ~strobe_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Pathway values per profile

  assign i2c_pd_val   = {6'h00, s_host[ppcb_pkg::BIT_XRST], ~s_host[ppcb_pkg::BIT_XCLK]};  // RULE14
  assign i2c_st_val   = {1'b0, s_pa[4], s_pa[3]};  // RULE14

  assign codec_pd_val = {4'h0, s_host[ppcb_pkg::BIT_CSEL], 1'b0,
                         s_host[ppcb_pkg::BIT_XRST], ~s_host[ppcb_pkg::BIT_XCLK]};  // RULE16
  assign codec_st_val = {1'b0, s_pd[2], 1'b0};  // RULE16

  assign xchg_pd_val  = {2'h0, s_host[ppcb_pkg::NYB_HI:ppcb_pkg::NYB_LO], 2'h0};  // RULE18
  assign xchg_st_val  = s_pa[ppcb_pkg::STAT_HI:ppcb_pkg::STAT_LO];  // RULE18

  assign vec_pd_val   = {1'b0, s_host[6:0]};  // RULE19
  assign hlth_st_val  = {s_pa[ppcb_pkg::ADDR_HLTH], 2'h0};  // RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Profile selection; health check wins since the init bit is the top bit

  assign prof_pd_val = sel_hlth  ? 8'h00 :
                       sel_rsvd  ? 8'h00 :
                       sel_i2c   ? i2c_pd_val :
                       sel_codec ? codec_pd_val :
                       sel_xchg  ? xchg_pd_val :
                       vec_pd_val;

  assign prof_pd_en  = sel_hlth  ? ppcb_pkg::PD_EN_NONE :
                       sel_rsvd  ? ppcb_pkg::PD_EN_NONE :  // RULE20
                       sel_i2c   ? ppcb_pkg::PD_EN_I2C :
                       sel_codec ? ppcb_pkg::PD_EN_CODEC :
                       sel_xchg  ? ppcb_pkg::PD_EN_XCHG :
                       ppcb_pkg::PD_EN_VEC;

  assign prof_st_val = sel_hlth  ? hlth_st_val :
                       sel_rsvd  ? 3'h0 :
                       sel_i2c   ? i2c_st_val :
                       sel_codec ? codec_st_val :
                       xchg_st_val;

  assign prof_st_en  = sel_hlth  ? ppcb_pkg::ST_EN_HLTH :
                       sel_rsvd  ? ppcb_pkg::ST_EN_NONE :  // RULE20
                       sel_i2c   ? ppcb_pkg::ST_EN_I2C :
                       sel_codec ? ppcb_pkg::ST_EN_CODEC :
                       ppcb_pkg::ST_EN_ALL;

  ////////////////////////////////////////////////////////////////////////////
  // Next output values

  always_comb begin
    next_pd_out  = 8'h00;
    next_pd_oe   = ppcb_pkg::PD_EN_NONE;  // RULE23
    next_st_out  = 3'h0;
    next_st_oe   = ppcb_pkg::ST_EN_NONE;  // RULE23
    next_csel_n  = 1'b0;
    next_wstrb_n = 1'b0;
    case (next_state)
      ppcb_pkg::ST_UNCFG: begin
        next_csel_n  = 1'b0;  // RULE3
        next_wstrb_n = 1'b0;  // RULE3
        next_pd_out  = cfg_pd_val;  // RULE7
        next_pd_oe   = ppcb_pkg::PD_EN_CFG;
      end
      ppcb_pkg::ST_CFG: begin
        next_csel_n  = ~s_host[ppcb_pkg::BIT_XCLK];  // RULE4 RULE10 RULE11
        next_wstrb_n = s_host[ppcb_pkg::BIT_XRST];  // RULE10 RULE11
        next_pd_out  = prof_pd_val & prof_pd_en;
        next_pd_oe   = prof_pd_en;
        next_st_out  = prof_st_val & prof_st_en;
        next_st_oe   = prof_st_en;
      end
      default: begin
        next_pd_oe = ppcb_pkg::PD_EN_NONE;
      end
    endcase
  end

  // A new load restarts the byte count
  assign next_byte_count = !s_host[ppcb_pkg::BIT_PROG] ? 16'h0000 :
                           (state == ppcb_pkg::ST_UNCFG && cclk_rise) ?
                           cfg_byte_count + 16'h0001 : cfg_byte_count;

  ////////////////////////////////////////////////////////////////////////////
  // State, clock path and profile registers

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= ppcb_pkg::ST_UNCFG;
      prof        <= ppcb_pkg::PR_HLTH;
      strobe_dly  <= '1;
      strobe_prev <= ppcb_pkg::STROBE_RST;
    end else begin
      state       <= next_state;
      prof        <= sel_hlth  ? ppcb_pkg::PR_HLTH :
                     sel_rsvd  ? ppcb_pkg::PR_RSVD :
                     sel_i2c   ? ppcb_pkg::PR_I2C :
                     sel_codec ? ppcb_pkg::PR_CODEC :
                     sel_xchg  ? ppcb_pkg::PR_XCHG : ppcb_pkg::PR_VEC;
      strobe_dly  <= {strobe_dly[ppcb_pkg::CCLK_SETUP_CYC-2:0], s_host[ppcb_pkg::BIT_STROBE]};
      strobe_prev <= strobe_dly[ppcb_pkg::CCLK_SETUP_CYC-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FPGA control pins

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_mode_sel_pin <= ppcb_pkg::MODE_SLAVE_PAR;
      fpga_tck         <= ppcb_pkg::TCK_IDLE;
      fpga_prog_n      <= ppcb_pkg::PROG_RST;
      fpga_cclk        <= ppcb_pkg::CCLK_RST;
    end else begin
      cfg_mode_sel_pin <= ppcb_pkg::MODE_SLAVE_PAR;  // RULE1
      fpga_tck         <= ppcb_pkg::TCK_IDLE;  // RULE9
      fpga_prog_n      <= s_host[ppcb_pkg::BIT_PROG];  // RULE2
      fpga_cclk        <= strobe_dly[ppcb_pkg::CCLK_SETUP_CYC-1];  // RULE8
    end
  end

  // Strobe pins are released with done but kept as driven host lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fpga_csel_n     <= 1'b1;
      fpga_csel_n_oe  <= 1'b0;
      fpga_wstrb_n    <= 1'b1;
      fpga_wstrb_n_oe <= 1'b0;
    end else begin
      fpga_csel_n     <= next_csel_n;
      fpga_csel_n_oe  <= 1'b1;
      fpga_wstrb_n    <= next_wstrb_n;
      fpga_wstrb_n_oe <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral bus and status pins

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_data_bus_out <= 8'h00;
      periph_data_bus_oe  <= ppcb_pkg::PD_EN_NONE;
      host_port_status    <= 3'h0;
      host_port_status_oe <= ppcb_pkg::ST_EN_NONE;
    end else begin
      periph_data_bus_out <= next_pd_out;
      periph_data_bus_oe  <= next_pd_oe;
      host_port_status    <= next_st_out;
      host_port_status_oe <= next_st_oe;
    end
  end

  // Address bus is only ever read here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_addr_bus_out <= 20'h00000;
      periph_addr_bus_oe  <= 20'h00000;
    end else begin
      periph_addr_bus_out <= 20'h00000;
      periph_addr_bus_oe  <= 20'h00000;  // RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Observation outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      user_signature <= 32'h00000000;
      cfg_active     <= 1'b0;
      profile_sel    <= 4'h0;
      cfg_byte_count <= 16'h0000;
    end else begin
      user_signature <= ppcb_pkg::USER_SIGNATURE;  // RULE22
      cfg_active     <= (state == ppcb_pkg::ST_UNCFG);
      profile_sel    <= profile_addr;
      cfg_byte_count <= next_byte_count;
    end
  end

endmodule : ppcb_top

// file: testbench/ppcb_monitor.sv
`timescale 1ns/10ps
module ppcb_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Host side
  input wire logic [7:0]  host_port_data,
  input wire logic [2:0]  host_port_status,
  input wire logic [2:0]  host_port_status_oe,
  // FPGA side
  input wire logic        cfg_mode_sel_pin,
  input wire logic        fpga_prog_n,
  input wire logic        fpga_csel_n,
  input wire logic        fpga_wstrb_n,
  input wire logic        fpga_init_n,
  input wire logic        fpga_done,
  input wire logic        fpga_tck,
  // Peripheral bus
  input wire logic [7:0]  periph_data_bus_out,
  input wire logic [7:0]  periph_data_bus_oe,
  input wire logic [19:0] periph_addr_bus_in,
  input wire logic [3:0]  profile_sel
);
  logic [2:0]  age;
  logic [16:0] p1, p2, p3;
  wire  [7:0]  h   = p3[7:0];
  wire  [5:0]  a   = p3[13:8];
  wire         cfg = p3[16];
  wire  [3:0]  pr  = {p3[15], a[2:0]};
  wire         ok  = age == 3'h7;
  ////////////////////////////////////////
  // Inputs aged by the sync and output stage
  always_ff @(posedge clk) begin
    p1 <= {fpga_done, fpga_init_n, periph_addr_bus_in[19], periph_addr_bus_in[5:0], host_port_data};
    p2 <= p1;
    p3 <= p2;
  end
  // Sync stages restart at their reset values, not the inputs, so skip the first edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) age <= 3'h0;
    else if (!ok) age <= age + 3'h1;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_fixed; cfg_mode_sel_pin == 1'b0 && fpga_tck == 1'b0; endproperty
  a_fixed: assert property (p_fixed) else $error("mode or scan clock not low");
  property p_prog; ok |-> fpga_prog_n == $past(host_port_data[7], 3); endproperty
  a_prog: assert property (p_prog) else $error("program line wrong");
  property p_ldcs; ok && !cfg |-> !fpga_csel_n && !fpga_wstrb_n; endproperty
  a_ldcs: assert property (p_ldcs) else $error("strobes not low while loading");
  property p_lddat; ok && !cfg |-> periph_data_bus_oe == 8'hFF
    && periph_data_bus_out[3:0] == h[5:2]; endproperty
  a_lddat: assert property (p_lddat) else $error("load byte wrong");
  property p_ifx; ok && cfg |-> fpga_csel_n == !h[1] && fpga_wstrb_n == h[6]; endproperty
  a_ifx: assert property (p_ifx) else $error("interchange lines wrong");
  property p_prof; ok |-> profile_sel == pr; endproperty
  a_prof: assert property (p_prof) else $error("profile wrong");
  property p_rsvd; ok && cfg && pr[3:2] == 2'b01 |-> periph_data_bus_oe == 8'h00
    && host_port_status_oe == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved profile drives");
  property p_hlth; ok && cfg && pr[3] |-> host_port_status_oe == 3'h4
    && host_port_status[2] == p3[14]; endproperty
  a_hlth: assert property (p_hlth) else $error("health path wrong");
  property p_i2c; ok && cfg && pr == 4'h0 |-> periph_data_bus_out[1:0] == {h[6], !h[1]}
    && host_port_status[1:0] == a[4:3]; endproperty
  a_i2c: assert property (p_i2c) else $error("two-wire path wrong");
  c_load: cover property (ok && !cfg);
  c_i2c: cover property (ok && cfg && pr == 4'h0);
  c_hlth: cover property (ok && cfg && pr[3]);
endmodule : ppcb_monitor

bind ppcb_top ppcb_monitor ppcb_monitor_i (
  .clk, .rst, .host_port_data, .host_port_status, .host_port_status_oe, .cfg_mode_sel_pin,
  .fpga_prog_n, .fpga_csel_n, .fpga_wstrb_n, .fpga_init_n, .fpga_done, .fpga_tck,
  .periph_data_bus_out, .periph_data_bus_oe, .periph_addr_bus_in, .profile_sel);

// file: testbench/ppcb_fpga_model.sv
`timescale 1ns/10ps
module ppcb_fpga_model #(
  parameter int NUM_BYTES = 4
) (
  // Configuration pins
  input  wire logic prog_n,
  input  wire logic cclk,
  output logic      done
);
  int got = 0;
  initial done = 1'b0;
  // Blank until loaded; any low program pulse restarts the load
  always @(negedge prog_n or posedge cclk) begin
    if (!prog_n) begin
      done = 1'b0;
      got = 0;
    end else if (!done) begin
      got = got + 1;
      if (got == NUM_BYTES) done = 1'b1;
    end
  end
endmodule : ppcb_fpga_model

// file: testbench/ppcb_top_bench.sv
`timescale 1ns/10ps
module ppcb_top_bench;
  localparam int NB = 5;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        d0   = 1'b1;
  logic [7:1]  hreg = 7'h7F;
  logic        init = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic [7:0]  fdrv = 8'h00;
  logic [31:0] seed = 32'hBDE6330D;
  logic [3:0]  held = 4'h0;
  logic [7:0]  q[$];
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  wire  [7:0]  h = {hreg, d0};
  wire  [7:0]  pd, po, pdi;
  wire  [2:0]  st, so;
  wire  [3:0]  prof;
  wire  [15:0] cnt;
  wire  [31:0] sig;
  wire         done, prog_n, cclk, csel_n, wstrb_n, coe, woe, act;
  wire  [19:0] aoe;
  // Shared data pins: the FPGA drives what the bridge leaves free
  assign pdi = (pd & po) | (fdrv & ~po);
  ppcb_top ppcb_top_i (.clk(clk), .rst(rst), .cfg_link_clk(d0), .host_port_data(h),
    .host_port_status(st), .host_port_status_oe(so), .cfg_mode_sel_pin(),
    .fpga_prog_n(prog_n), .fpga_cclk(cclk), .fpga_csel_n(csel_n), .fpga_csel_n_oe(coe),
    .fpga_wstrb_n(wstrb_n), .fpga_wstrb_n_oe(woe), .fpga_init_n(init), .fpga_done(done),
    .fpga_tck(), .periph_data_bus_in(pdi), .periph_data_bus_out(pd),
    .periph_data_bus_oe(po), .periph_addr_bus_in(addr), .periph_addr_bus_out(),
    .periph_addr_bus_oe(aoe), .user_signature(sig), .cfg_active(act), .profile_sel(prof),
    .cfg_byte_count(cnt));
  ppcb_fpga_model #(.NUM_BYTES(NB)) ppcb_fpga_model_i (.prog_n(prog_n), .cclk(cclk),
    .done(done));
  ////////////////////////////////////////
  always #4 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Reference model of the bridge data, status, strobe, program and profile outputs
  task automatic check_all;
    logic [7:0] ed, eo;
    logic [2:0] es, eso;
    ed = 8'h00; eo = 8'h00; es = 3'h0; eso = 3'h0;
    if (!done) begin
      ed = {held, h[5:2]}; eo = 8'hFF;
    end else if (init) begin
      es[2] = addr[19]; eso = 3'h4;
    end else begin
      case (addr[2:0])
        3'h0: begin ed[1:0] = {h[6], ~h[1]}; eo = 8'h03; es[1:0] = addr[4:3]; eso = 3'h3; end
        3'h1: begin ed[3:0] = {h[5], 1'b0, h[6], ~h[1]}; eo = 8'h0B; es[1] = pdi[2]; eso = 3'h2; end
        3'h2: begin ed[5:2] = h[5:2]; eo = 8'h3C; es = addr[5:3]; eso = 3'h7; end
        3'h3: begin ed[6:0] = h[6:0]; eo = 8'h7F; es = addr[5:3]; eso = 3'h7; end
        default: ;
      endcase
    end
    check_eq(pd, ed);
    check_eq(po, eo);
    check_eq(st, es);
    check_eq(so, eso);
    check_eq({prog_n, csel_n, wstrb_n}, {h[7], done & ~h[1], done & h[6]});
    check_eq(prof, {init, addr[2:0]});
    check_eq({act, coe, woe, aoe}, {~done, 2'b11, 20'h00000});
  endtask : check_all
  // One byte per link period, upper nybble first
  task automatic send_byte(input logic [7:0] b);
    q.push_back(b);
    @(posedge clk) hreg[5:2] <= b[7:4];
    #37 d0 = 1'b0;
    held = b[7:4];
    #40 @(posedge clk) hreg[5:2] <= b[3:0];
    #37 d0 = 1'b1;
    #80;
  endtask : send_byte
  always @(posedge cclk) if (q.size() > 0) check_eq(pd, q.pop_front());
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize;
    end
  end
  ////////////////////////////////////////
  initial begin
    tick(10);
    rst <= 1'b0;
    tick(6);
    check_all;
    check_eq(sig, ppcb_pkg::USER_SIGNATURE);
    $display("test reset done");
    hreg[7] <= 1'b0;
    tick(6);
    check_all;
    hreg[7] <= 1'b1;
    tick(6);
    for (int i = 0; i < NB; i++) begin
      seed = lfsr(seed);
      send_byte(seed[7:0]);
      tick(2);
      check_all;
    end
    check_eq(q.size(), 0);
    check_eq(cnt, NB);
    $display("test load done");
    for (int i = 0; i < 18; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      init <= (i % 9) == 8;
      addr <= {seed[19:3], 3'(i % 9)};
      hreg[6:1] <= seed[25:20];
      fdrv <= seed[31:24];
      tick(5);
      check_all;
    end
    $display("test paths done");
    summarize;
  end
endmodule : ppcb_top_bench
